//--- dv/iapf_cpu_model.sv
`timescale 1ns/1ns
// Behavioural CPU core: ends an instruction every fourth state and answers vector reads.
module iapf_cpu_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic run,
  input wire logic cpu_hold,
  input iapf_pkg::iapf_mem_t mem_bus,
  output logic instr_done,
  output logic [15:0] mem_rdata
);
  logic [1:0] phase;

  // The core stands still while entry holds it, so no boundary is reported mid-sequence.
  always_ff @(posedge clk_sys) begin
    if (srst || !run || cpu_hold) begin
      phase <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      instr_done <= (phase == 2'h3);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outside a read the data keep changing, so a late sample cannot pass by chance.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_rdata <= 16'h0000;
    end else if (mem_bus.rd) begin
      mem_rdata <= {8'hC3, mem_bus.addr[7:0]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- dv/tb.sv
`timescale 1ns/1ns
// Self-checking bench for pin-function side effects, flag clearing and interrupt entry.
module tb;
  logic clk_sys;
  logic srst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr, reg_rd, instr_done, rte_done, run, hold_q;
  logic [7:0] reg_rdata, cpu_flags, restored_flags;
  logic [4:0] ext_edge_input_n;
  logic [7:0] wake_input_n;
  logic [15:0] resume_pc, stack_ptr, rte_word, mem_rdata, new_sp, handler_pc, seed, vaddr;
  logic cpu_hold, cpu_mask, handler_go;
  iapf_pkg::iapf_mem_t mem_bus;
  int fail_count, num_checks, hold_cnt, ref_req, n;
  logic [15:0] wa[$], wd[$], ra[$];

  iapf_ctrl i_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_edge_input_n(ext_edge_input_n),
    .wake_input_n(wake_input_n), .instr_done(instr_done), .resume_pc(resume_pc), .cpu_flags(cpu_flags),
    .stack_ptr(stack_ptr), .rte_done(rte_done), .rte_word(rte_word), .mem_rdata(mem_rdata),
    .mem_bus(mem_bus), .cpu_hold(cpu_hold), .cpu_mask(cpu_mask), .restored_flags(restored_flags),
    .new_sp(new_sp), .handler_go(handler_go), .handler_pc(handler_pc));

  iapf_cpu_model i_cpu (.clk_sys(clk_sys), .srst(srst), .run(run), .cpu_hold(cpu_hold),
    .mem_bus(mem_bus), .instr_done(instr_done), .mem_rdata(mem_rdata));

  //////////////////////////////////////////////////////////////////////////////
  // Clock and a monitor that records every word access and every entry.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (mem_bus.we) begin
      wa.push_back(mem_bus.addr);
      wd.push_back(mem_bus.wdata);
    end
    if (mem_bus.rd) begin
      ra.push_back(mem_bus.addr);
    end
    if (cpu_hold === 1'b1 && hold_q !== 1'b1) begin
      hold_cnt++;
    end
    hold_q <= cpu_hold;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Every strobe is dropped one edge before the next task may raise it again.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
    @(posedge clk_sys);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // Fresh context for the next entry; the stack pointer is always kept even.
  task automatic newctx;
    seed = lfsr(seed);
    resume_pc <= seed;
    seed = lfsr(seed);
    cpu_flags <= seed[7:0];
    stack_ptr <= {seed[15:1], 1'b0};
  endtask

  task print_verdict;
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A run of this length is far beyond the few hundred states the sequence needs.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    print_verdict;
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, run, rte_done, rte_word, cpu_flags} = '0;
    {resume_pc, stack_ptr} = '0;
    ext_edge_input_n = 5'h1F;
    wake_input_n = 8'hFF;
    seed = 16'hD4B1;
    hold_cnt = 0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], (a == 7) ? 8'h80 : 8'h00);
    end
    chk("reset mask", 16'h0001, {15'h0000, cpu_mask});
    // Pins low while functions are switched on produce flags with no real edge.
    ext_edge_input_n <= 5'h00;
    wake_input_n <= 8'h00;
    cyc(8);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h0E);
    wr(4'h1, 8'h11);
    wr(4'h2, 8'hFF);
    cyc(8);
    rd(4'h5, 8'h1F);
    rd(4'h6, 8'hFF);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h1F);
    run <= 1'b1;
    cyc(12);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    rd(4'h5, 8'h00);
    rd(4'h6, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00);
    wr(4'h3, 8'h10);
    wr(4'h1, 8'h01);
    cyc(8);
    rd(4'h5, 8'h10);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h11);
    cyc(12);
    wr(4'h5, 8'h00);
    // Real pin edges, first with falling and then with rising sense.
    ext_edge_input_n <= 5'h1F;
    wake_input_n <= 8'hFF;
    cyc(8);
    rd(4'h5, 8'h00);
    ext_edge_input_n <= 5'h00;
    wake_input_n <= 8'h00;
    cyc(8);
    rd(4'h5, 8'h1F);
    rd(4'h6, 8'hFF);
    wr(4'h5, 8'h00);
    wr(4'h3, 8'h1F);
    ext_edge_input_n <= 5'h1F;
    wake_input_n <= 8'hFF;
    cyc(8);
    rd(4'h5, 8'h1F);
    wr(4'h7, 8'h00);
    cyc(40);
    chk("entries", 16'h0000, hold_cnt[15:0]);
    wr(4'h7, 8'h80);
    wr(4'h4, 8'h3F);
    cyc(40);
    chk("entries", 16'h0000, hold_cnt[15:0]);
    newctx;
    wa.delete();
    wd.delete();
    ra.delete();
    ref_req = 32'h3F;
    wr(4'h7, 8'h00);
    for (int k = 0; k < 6; k++) begin
      vaddr = (k < 5) ? 16'(2 * (4 + k)) : 16'h0012;
      n = 0;
      while (cpu_hold !== 1'b1 && n < 100) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk("mask set", 16'h0001, {15'h0000, cpu_mask});
      chk("new sp", stack_ptr - 16'h0004, new_sp);
      n = 0;
      while (handler_go !== 1'b1 && n < 40) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk("latency", 16'h000E, n[15:0]);
      chk("pc addr", (stack_ptr - 16'h0002) & 16'hFFFE, wa[0]);
      chk("pc word", resume_pc, wd[0]);
      chk("flag addr", (stack_ptr - 16'h0004) & 16'hFFFE, wa[1]);
      chk("flag word", {cpu_flags, cpu_flags}, wd[1]);
      chk("vector", vaddr, ra[0]);
      chk("handler", {8'hC3, vaddr[7:0]}, handler_pc);
      rd(4'h5, ref_req[4:0]);
      if (k < 5) begin
        wr(4'h5, ~(8'h01 << k));
      end else begin
        wr(4'h6, 8'h00);
      end
      ref_req = ref_req & ~(1 << k);
      wa.delete();
      wd.delete();
      ra.delete();
      newctx;
      seed = lfsr(seed);
      rte_word <= {1'b0, seed[14:0]};
      rte_done <= 1'b1;
      @(posedge clk_sys);
      rte_done <= 1'b0;
      #1;
      chk("restored", {8'h00, rte_word[15:8]}, {8'h00, restored_flags});
      chk("unmask", 16'h0000, {15'h0000, cpu_mask});
    end
    cyc(40);
    chk("entries", 16'h0006, hold_cnt[15:0]);
    print_verdict;
  end
endmodule

//--- verilog/iapf_ctrl.sv
`timescale 1ns/1ns
module iapf_ctrl (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [4:0] ext_edge_input_n,
  input wire logic [7:0] wake_input_n,
  input wire logic instr_done,
  input wire logic [15:0] resume_pc,
  input wire logic [7:0] cpu_flags,
  input wire logic [15:0] stack_ptr,
  input wire logic rte_done,
  input wire logic [15:0] rte_word,
  input wire logic [15:0] mem_rdata,
  output iapf_pkg::iapf_mem_t mem_bus,
  output logic cpu_hold,
  output logic cpu_mask,
  output logic [7:0] restored_flags,
  output logic [15:0] new_sp,
  output logic handler_go,
  output logic [15:0] handler_pc
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and declarations.

  logic [7:0] pin_function_reg_one;
  logic [7:0] pin_function_reg_two;
  logic [7:0] wake_pin_function_reg;
  logic [7:0] edge_polarity_reg;
  logic [7:0] enable_reg_one;
  logic [4:0] request_flags_reg_one;
  logic [7:0] wake_request_flags_reg;
  logic [12:0] pin_s1;
  logic [12:0] pin_s2;
  logic [12:0] pin_s3;
  logic [12:0] pin_lvl;
  logic [12:0] eff_prev;
  logic [12:0] eff_now;
  logic [4:0] ext_fn;
  logic [4:0] ext_set;
  logic [7:0] wake_set;
  logic [5:0] pending;
  logic [1:0] guard;
  logic accept;
  logic [3:0] vec_num;
  logic [7:0] saved_flags;
  logic [15:0] saved_pc;
  logic [1:0] cnt;
  logic phase_end;
  iapf_pkg::iapf_state_t state;
  iapf_pkg::iapf_state_t next_state;
  iapf_pkg::iapf_mem_t next_mem;

  // Flag update: a written zero clears, a written one does nothing, and a set
  // arriving in the same cycle wins over the clear.
  function automatic logic [7:0] flag_update(input logic [7:0] old, input logic [7:0] set,
                                             input logic clr_en, input logic [7:0] wdata);
    logic [7:0] kept;
    kept = clr_en ? (old & wdata) : old;
    return kept | set;
  endfunction

  // Vector of the highest-priority pending source; wake inputs come last.
  function automatic logic [3:0] pick_vector(input logic [5:0] pend);
    logic [3:0] v;
    v = iapf_pkg::VEC_WAKE;
    for (int i = iapf_pkg::NUM_EXT - 1; i >= 0; i--) begin
      if (pend[i]) begin
        v = iapf_pkg::VEC_EXT0 + 4'(i);
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. A level counts once the second and third stage agree,
  // so a single-cycle glitch near the sampling edge cannot make an edge.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_s1 <= iapf_pkg::RST_PIN_LVL;
      pin_s2 <= iapf_pkg::RST_PIN_LVL;
      pin_s3 <= iapf_pkg::RST_PIN_LVL;
      pin_lvl <= iapf_pkg::RST_PIN_LVL;
    end else begin
      pin_s1 <= {wake_input_n, ext_edge_input_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_lvl & (pin_s2 ^ pin_s3));
    end
  end

  // A pin whose function is off looks high to the detector, so switching the
  // function while the pin is low is itself an edge.
  assign ext_fn = {pin_function_reg_two[4], pin_function_reg_one[3:1], pin_function_reg_two[0]};
  assign eff_now = pin_lvl | ~{wake_pin_function_reg, ext_fn};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      eff_prev <= iapf_pkg::RST_PIN_LVL;
    end else begin
      eff_prev <= eff_now;
    end
  end

  // Edge select zero means falling, one means rising.
  always_comb begin
    for (int i = 0; i < iapf_pkg::NUM_EXT; i++) begin
      ext_set[i] = edge_polarity_reg[i] ? (~eff_prev[i] & eff_now[i]) : (eff_prev[i] & ~eff_now[i]);
    end
    wake_set = eff_prev[12:5] & ~eff_now[12:5];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_function_reg_one <= iapf_pkg::RST_REG;
      pin_function_reg_two <= iapf_pkg::RST_REG;
      wake_pin_function_reg <= iapf_pkg::RST_REG;
      edge_polarity_reg <= iapf_pkg::RST_REG;
      enable_reg_one <= iapf_pkg::RST_REG;
    end else if (reg_wr) begin
      unique case (reg_addr)
        iapf_pkg::OFF_PIN_FN_ONE: pin_function_reg_one <= reg_wdata;
        iapf_pkg::OFF_PIN_FN_TWO: pin_function_reg_two <= reg_wdata;
        iapf_pkg::OFF_WAKE_FN: wake_pin_function_reg <= reg_wdata;
        iapf_pkg::OFF_EDGE_POL: edge_polarity_reg <= reg_wdata;
        iapf_pkg::OFF_ENABLE_ONE: enable_reg_one <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Guard against clearing flags in the instruction right after a pin function
  // write: the write's own boundary and the next one must pass first.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      guard <= 2'h0;
    end else if (reg_wr && (reg_addr == iapf_pkg::OFF_PIN_FN_ONE || reg_addr == iapf_pkg::OFF_PIN_FN_TWO ||
                            reg_addr == iapf_pkg::OFF_WAKE_FN)) begin
      guard <= 2'h2;
    end else if (instr_done && guard != 2'h0) begin
      guard <= guard - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request flags. Acceptance never touches them; only software zeros clear.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      request_flags_reg_one <= 5'h00;
      wake_request_flags_reg <= iapf_pkg::RST_REG;
    end else begin
      request_flags_reg_one <= 5'(flag_update({3'h0, request_flags_reg_one}, {3'h0, ext_set},
                                   reg_wr && reg_addr == iapf_pkg::OFF_REQ_ONE && guard == 2'h0,
                                   reg_wdata));
      wake_request_flags_reg <= flag_update(wake_request_flags_reg, wake_set,
                                            reg_wr && reg_addr == iapf_pkg::OFF_WAKE_REQ && guard == 2'h0,
                                            reg_wdata);
    end
  end

  // Only enabled sources reach the selector; wake inputs share one enable.
  assign pending = {|wake_request_flags_reg & enable_reg_one[iapf_pkg::WAKE_EN_BIT],
                    request_flags_reg_one & enable_reg_one[4:0]};

  // Acceptance looks at an instruction boundary, an idle sequencer, an open mask and a pending source.
  assign accept = instr_done && state == iapf_pkg::IAPF_IDLE && !cpu_mask && pending != 6'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the read strobe.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= iapf_pkg::RST_REG;
    end else if (reg_rd) begin
      unique case (reg_addr)
        iapf_pkg::OFF_PIN_FN_ONE: reg_rdata <= pin_function_reg_one;
        iapf_pkg::OFF_PIN_FN_TWO: reg_rdata <= pin_function_reg_two;
        iapf_pkg::OFF_WAKE_FN: reg_rdata <= wake_pin_function_reg;
        iapf_pkg::OFF_EDGE_POL: reg_rdata <= edge_polarity_reg;
        iapf_pkg::OFF_ENABLE_ONE: reg_rdata <= enable_reg_one;
        iapf_pkg::OFF_REQ_ONE: reg_rdata <= {3'h0, request_flags_reg_one};
        iapf_pkg::OFF_WAKE_REQ: reg_rdata <= wake_request_flags_reg;
        iapf_pkg::OFF_CPU_FLAG: reg_rdata <= {cpu_mask, 7'h00};
        default: reg_rdata <= iapf_pkg::RST_REG;
      endcase
    end else begin
      reg_rdata <= iapf_pkg::RST_REG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mask bit: set on acceptance, written by software, reloaded on return.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cpu_mask <= iapf_pkg::RST_CPU_FLAG[iapf_pkg::MASK_BIT];
    end else if (accept) begin
      cpu_mask <= 1'b1;
    end else if (rte_done) begin
      cpu_mask <= rte_word[8 + iapf_pkg::MASK_BIT];
    end else if (reg_wr && reg_addr == iapf_pkg::OFF_CPU_FLAG) begin
      cpu_mask <= reg_wdata[iapf_pkg::MASK_BIT];
    end
  end

  // On return the even-address byte is the upper half; the odd byte is dropped.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      restored_flags <= iapf_pkg::RST_CPU_FLAG;
    end else if (rte_done) begin
      restored_flags <= rte_word[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Entry sequencer. One state per clk_sys cycle; the phase lengths are the
  // fixed entry budget, so the entry always takes the same fourteen states.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vec_num <= iapf_pkg::VEC_WAKE;
      saved_flags <= iapf_pkg::RST_REG;
      saved_pc <= 16'h0000;
    end else if (accept) begin
      vec_num <= pick_vector(pending);
      saved_flags <= cpu_flags;
      saved_pc <= resume_pc;
    end
  end

  always_comb begin
    unique case (state)
      iapf_pkg::IAPF_PUSH_PC, iapf_pkg::IAPF_PUSH_FLAG: phase_end = cnt == iapf_pkg::LEN_PUSH_WORD - 2'h1;
      iapf_pkg::IAPF_VECTOR: phase_end = cnt == iapf_pkg::LEN_VECTOR - 2'h1;
      iapf_pkg::IAPF_FETCH: phase_end = cnt == iapf_pkg::LEN_FETCH - 2'h1;
      iapf_pkg::IAPF_INTERNAL: phase_end = cnt == iapf_pkg::LEN_INTERNAL - 2'h1;
      default: phase_end = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      iapf_pkg::IAPF_IDLE: if (accept) next_state = iapf_pkg::IAPF_PUSH_PC;
      iapf_pkg::IAPF_PUSH_PC: if (phase_end) next_state = iapf_pkg::IAPF_PUSH_FLAG;
      iapf_pkg::IAPF_PUSH_FLAG: if (phase_end) next_state = iapf_pkg::IAPF_VECTOR;
      iapf_pkg::IAPF_VECTOR: if (phase_end) next_state = iapf_pkg::IAPF_FETCH;
      iapf_pkg::IAPF_FETCH: if (phase_end) next_state = iapf_pkg::IAPF_INTERNAL;
      iapf_pkg::IAPF_INTERNAL: if (phase_end) next_state = iapf_pkg::IAPF_IDLE;
      default: next_state = iapf_pkg::IAPF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= iapf_pkg::IAPF_IDLE;
      cnt <= 2'h0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 2'h0 : cnt + 2'h1;
    end
  end

  // Bus requests for the first cycle of the two push phases and the vector phase. Every access is a word and
  // bit zero of the address is forced low.
  always_comb begin
    next_mem = '0;
    if (cnt == 2'h0) begin
      unique case (state)
        iapf_pkg::IAPF_PUSH_PC: begin
          next_mem.we = 1'b1;
          next_mem.addr = (stack_ptr - iapf_pkg::WORD_BYTES) & 16'hFFFE;
          next_mem.wdata = saved_pc;
        end
        iapf_pkg::IAPF_PUSH_FLAG: begin
          next_mem.we = 1'b1;
          next_mem.addr = (stack_ptr - 16'(2 * iapf_pkg::WORD_BYTES)) & 16'hFFFE;
          next_mem.wdata = {saved_flags, saved_flags};
        end
        iapf_pkg::IAPF_VECTOR: begin
          next_mem.rd = 1'b1;
          next_mem.addr = {11'h000, vec_num, 1'b0};
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_bus <= '0;
    end else begin
      mem_bus <= next_mem;
    end
  end

  // Read data stand one cycle after the registered read, at the fetch start.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      handler_pc <= 16'h0000;
    end else if (state == iapf_pkg::IAPF_FETCH && cnt == 2'h0) begin
      handler_pc <= mem_rdata & 16'hFFFE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      handler_go <= 1'b0;
      cpu_hold <= 1'b0;
      new_sp <= 16'h0000;
    end else begin
      handler_go <= state == iapf_pkg::IAPF_INTERNAL && phase_end;
      cpu_hold <= next_state != iapf_pkg::IAPF_IDLE;
      new_sp <= accept ? ((stack_ptr - 16'(2 * iapf_pkg::WORD_BYTES)) & 16'hFFFE) : new_sp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_mask_blocks;
    @(posedge clk_sys) disable iff (srst) cpu_mask |-> !accept;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("accepted while masked");

  property p_accept_masks;
    @(posedge clk_sys) disable iff (srst) accept |=> cpu_mask && cpu_hold;
  endproperty
  a_accept_masks: assert property (p_accept_masks) else $error("mask not set on accept");

  property p_entry_time;
    @(posedge clk_sys) disable iff (srst) accept |-> ##15 handler_go;
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("entry length wrong");

  property p_word_align;
    @(posedge clk_sys) disable iff (srst) (mem_bus.we || mem_bus.rd) |-> !mem_bus.addr[0];
  endproperty
  a_word_align: assert property (p_word_align) else $error("odd word address");

  property p_flag_word;
    @(posedge clk_sys) disable iff (srst)
      accept |-> ##4 (mem_bus.we && mem_bus.wdata[15:8] == mem_bus.wdata[7:0] && mem_bus.wdata[7:0] == saved_flags);
  endproperty
  a_flag_word: assert property (p_flag_word) else $error("flags not stacked as word");

  property p_pc_push;
    @(posedge clk_sys) disable iff (srst) accept |-> ##2 (mem_bus.we && mem_bus.wdata == $past(resume_pc, 2));
  endproperty
  a_pc_push: assert property (p_pc_push) else $error("wrong counter stacked");

  property p_guard_clear;
    @(posedge clk_sys) disable iff (srst)
      (reg_wr && reg_addr == iapf_pkg::OFF_REQ_ONE && guard != 2'h0)
      |=> (request_flags_reg_one & $past(request_flags_reg_one)) == $past(request_flags_reg_one);
  endproperty
  a_guard_clear: assert property (p_guard_clear) else $error("guarded clear took effect");

  property p_no_auto_clear;
    @(posedge clk_sys) disable iff (srst)
      (accept && !reg_wr) |=> (request_flags_reg_one & $past(request_flags_reg_one)) == $past(request_flags_reg_one);
  endproperty
  a_no_auto_clear: assert property (p_no_auto_clear) else $error("flag cleared by accept");

  property p_top_priority;
    @(posedge clk_sys) disable iff (srst) (accept && pending[0]) |=> vec_num == iapf_pkg::VEC_EXT0;
  endproperty
  a_top_priority: assert property (p_top_priority) else $error("priority order wrong");

  property p_rte_even;
    @(posedge clk_sys) disable iff (srst) rte_done |=> restored_flags == $past(rte_word[15:8]);
  endproperty
  a_rte_even: assert property (p_rte_even) else $error("odd byte restored");

endmodule

//--- verilog/iapf_pkg.sv
package iapf_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFF_PIN_FN_ONE = 4'h0;
  localparam logic [3:0] OFF_PIN_FN_TWO = 4'h1;
  localparam logic [3:0] OFF_WAKE_FN = 4'h2;
  localparam logic [3:0] OFF_EDGE_POL = 4'h3;
  localparam logic [3:0] OFF_ENABLE_ONE = 4'h4;
  localparam logic [3:0] OFF_REQ_ONE = 4'h5;
  localparam logic [3:0] OFF_WAKE_REQ = 4'h6;
  localparam logic [3:0] OFF_CPU_FLAG = 4'h7;

  // Field positions.
  localparam int WAKE_EN_BIT = 5;
  localparam int MASK_BIT = 7;
  localparam int NUM_EXT = 5;
  localparam int NUM_WAKE = 8;

  // Values after reset.
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_CPU_FLAG = 8'h80;
  localparam logic [12:0] RST_PIN_LVL = 13'h1FFF;

  // Vector numbers, in priority order from highest to lowest.
  localparam logic [3:0] VEC_EXT0 = 4'h4;
  localparam logic [3:0] VEC_WAKE = 4'h9;

  // Entry phase lengths in states, zero standing for four; one state is one clk_sys cycle.
  localparam logic [1:0] LEN_PUSH_WORD = 2'h2;
  localparam logic [1:0] LEN_VECTOR = 2'h2;
  localparam logic [1:0] LEN_FETCH = 2'h0;
  localparam logic [1:0] LEN_INTERNAL = 2'h0;
  localparam logic [15:0] WORD_BYTES = 16'h0002;

  typedef enum logic [5:0] {
    IAPF_IDLE = 6'h01,
    IAPF_PUSH_PC = 6'h02,
    IAPF_PUSH_FLAG = 6'h04,
    IAPF_VECTOR = 6'h08,
    IAPF_FETCH = 6'h10,
    IAPF_INTERNAL = 6'h20
  } iapf_state_t;

  // Memory request toward the core's bus; words only.
  typedef struct packed {
    logic we;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iapf_mem_t;

endpackage
